// ==== include/fmsc_regs.vh ====
// Register offsets, field positions and reset values of the float-mode
// slot configuration bank.
// Assumes inclusion by bare name from the logic files.
`ifndef FMSC_REGS_VH
`define FMSC_REGS_VH

`define FMSC_ADDR_W           8
`define FMSC_DATA_W           16

// Register offsets
`define FMSC_OFS_PULSE_WIDTH  8'h57
`define FMSC_OFS_SLOT_B_CTRL  8'h59
`define FMSC_OFS_PULSE_MASK   8'h5A
`define FMSC_OFS_SLOT_A_CTRL  8'h5E

// Reset values
`define FMSC_RST_PULSE_WIDTH  16'h0320
`define FMSC_RST_SLOT_CTRL    16'h0808
`define FMSC_RST_PULSE_MASK   16'h0010
`define FMSC_RST_ZERO         16'h0000

// Fields of the slot float control registers
`define FMSC_EN_HI            14
`define FMSC_EN_LO            13
`define FMSC_PRECON_HI        12
`define FMSC_PRECON_LO        8
`define FMSC_EN_FLOAT         2'h3
`define FMSC_EN_OFF           2'h0

// Fields of the pulse mask register
`define FMSC_MASK_B_HI        15
`define FMSC_MASK_B_LO        12
`define FMSC_MASK_A_HI        11
`define FMSC_MASK_A_LO        8

// Fields of the float pulse width register
`define FMSC_WIDTH_HI         12
`define FMSC_WIDTH_LO         8
`define FMSC_OFFSET_HI        7
`define FMSC_OFFSET_LO        0

// Typical preconditioning delay in microseconds, as a reference figure
`define FMSC_PRECON_TYP_US    16

`endif

// ==== logic/fmsc_float_cfg.v ====
// Float-mode slot configuration register bank: slot enables,
// preconditioning delays, per-position LED fire masks and pulse width.
// Assumes the host port decoder runs on i_mclk and presents one-cycle
// write and read strobes with address and data valid in the same cycle.
// No synchronisers: every input already belongs to the i_mclk domain.
`timescale 1ns/1ps
`include "fmsc_regs.vh"

// Overview of operation
// R1: Slot B enable field: 0 disables, 3 enables float, 1 and 2 reserved.
// R2: Slot A enable field: 0 disables, 3 enables float, 1 and 2 reserved.
// R3: Slot B five-bit preconditioning delay to first float period, reset 0x08.
// R4: Slot A five-bit preconditioning delay to first float period, reset 0x08.
// R5: Each mask bit covers one of four pulse positions; one suppresses firing.
// R6: Slot B mask in bits 15..12; bit 12 first pulse, bit 15 fourth.
// R7: Slot A mask in bits 11..8; bit 8 first pulse, bit 11 fourth.
// R8: Slot B float pulse width is five bits in 1 us steps.
// R9: Software writes reserved bits only with their documented defaults.
module fmsc_float_cfg (
	// Clock and reset
	input  wire        i_mclk,
	input  wire        i_rst_n,
	// Host register port
	input  wire [7:0]  i_addr,
	input  wire        i_wr_en,
	input  wire [15:0] i_wdata,
	input  wire        i_rd_en,
	output wire [15:0] o_rdata,
	output wire        o_rd_valid,
	// Slot B settings
	output wire [1:0]  o_slot_b_float_enable,
	output wire        o_slot_b_float_on,
	output wire [4:0]  o_slot_b_float_precondition_time,
	output wire [3:0]  o_slot_b_pulse_fire_mask,
	output wire [4:0]  o_slot_b_float_pulse_width,
	output wire [7:0]  o_slot_b_float_pulse_offset,
	// Slot A settings
	output wire [1:0]  o_slot_a_float_enable,
	output wire        o_slot_a_float_on,
	output wire [4:0]  o_slot_a_float_precondition_time,
	output wire [3:0]  o_slot_a_pulse_fire_mask
);

	// Slot indices of the per-slot generate loop
	localparam SLOT_A = 0;
	localparam SLOT_B = 1;
	localparam N_SLOT = 2;
	// Every access is one full host word; there are no byte lanes
	localparam DW     = `FMSC_DATA_W;

	// Address decode, shared by the write and the read path
	wire                 hit_width;
	wire                 hit_mask;
	wire [N_SLOT-1:0]    hit_ctrl;

	// Write strobes, one per register
	wire                 we_width;
	wire                 we_mask;
	wire [N_SLOT-1:0]    we_ctrl;

	// Stored register words
	reg  [DW-1:0]        width_q;
	reg  [DW-1:0]        width_d;
	reg  [DW-1:0]        mask_q;
	reg  [DW-1:0]        mask_d;
	wire [N_SLOT*DW-1:0] ctrl_w;
	wire [DW-1:0]        ctrl_a_w;
	wire [DW-1:0]        ctrl_b_w;
	wire [N_SLOT-1:0]    on_w;

	// Read path
	reg  [DW-1:0]        rdata_q;
	reg  [DW-1:0]        rdata_d;
	reg                  rd_valid_q;
	reg                  rd_valid_d;

	assign hit_width        = (i_addr == `FMSC_OFS_PULSE_WIDTH);
	assign hit_mask         = (i_addr == `FMSC_OFS_PULSE_MASK);
	assign hit_ctrl[SLOT_A] = (i_addr == `FMSC_OFS_SLOT_A_CTRL);
	assign hit_ctrl[SLOT_B] = (i_addr == `FMSC_OFS_SLOT_B_CTRL);

	// Unmapped offsets raise no strobe, so such writes are dropped
	assign we_width = i_wr_en & hit_width;
	assign we_mask  = i_wr_en & hit_mask;
	assign we_ctrl  = {N_SLOT{i_wr_en}} & hit_ctrl;

	// Reserved bits are stored as written so a read-back shows what
	// software left there; masking them would hide a bad write

	// Float pulse width and first-pulse offset of slot B
	always @* begin
		width_d = width_q;
		if (we_width) begin
			width_d = i_wdata; // [R8]
		end
	end

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			width_q <= `FMSC_RST_PULSE_WIDTH; // [R8]
		end else begin
			width_q <= width_d;
		end
	end

	// LED fire masks of both slots share one word
	always @* begin
		mask_d = mask_q;
		if (we_mask) begin
			mask_d = i_wdata; // [R6] [R7]
		end
	end

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_q <= `FMSC_RST_PULSE_MASK; // [R5]
		end else begin
			mask_q <= mask_d;
		end
	end

	// One control word and one float flag per slot; only the decode differs
	genvar g;
	generate
		for (g = 0; g < N_SLOT; g = g + 1) begin : g_slot
			reg  [DW-1:0] ctrl_q;
			reg  [DW-1:0] ctrl_d;
			reg           on_q;
			reg           on_d;

			always @* begin
				ctrl_d = ctrl_q;
				if (we_ctrl[g]) begin
					ctrl_d = i_wdata; // [R3] [R4]
				end
				// Reserved codes 1 and 2 leave float off rather than guess
				on_d = (ctrl_d[`FMSC_EN_HI:`FMSC_EN_LO]
					== `FMSC_EN_FLOAT); // [R1] [R2]
			end

			// The flag is taken from the next word so it moves with it
			always @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					ctrl_q <= `FMSC_RST_SLOT_CTRL; // [R3] [R4]
					on_q   <= 1'b0;
				end else begin
					ctrl_q <= ctrl_d;
					on_q   <= on_d;
				end
			end

			assign ctrl_w[g*DW +: DW] = ctrl_q;
			assign on_w[g]            = on_q;
		end
	endgenerate

	assign ctrl_a_w = ctrl_w[SLOT_A*DW +: DW];
	assign ctrl_b_w = ctrl_w[SLOT_B*DW +: DW];

	// Read mux; a read and a write in one cycle return the old word
	// Offsets are distinct, so at most one hit is set
	always @* begin
		// The valid pulse follows every read strobe, mapped or not
		rd_valid_d = i_rd_en;
		rdata_d    = `FMSC_RST_ZERO;
		if (hit_width) begin
			rdata_d = width_q;
		end
		if (hit_mask) begin
			rdata_d = mask_q;
		end
		if (hit_ctrl[SLOT_A]) begin
			rdata_d = ctrl_a_w;
		end
		if (hit_ctrl[SLOT_B]) begin
			rdata_d = ctrl_b_w;
		end
	end

	// Read data is held until the next read strobe
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q    <= `FMSC_RST_ZERO;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_valid_d;
			if (i_rd_en) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign o_rdata    = rdata_q;
	assign o_rd_valid = rd_valid_q;

	// Enable codes 1 and 2 read back as written; only the flag ignores them
	// Slot B fields
	assign o_slot_b_float_enable =
		ctrl_b_w[`FMSC_EN_HI:`FMSC_EN_LO]; // [R1]
	assign o_slot_b_float_on = on_w[SLOT_B]; // [R1]
	assign o_slot_b_float_precondition_time =
		ctrl_b_w[`FMSC_PRECON_HI:`FMSC_PRECON_LO]; // [R3]
	// Bit 0 of each mask is the first pulse; a one suppresses it [R5]
	assign o_slot_b_pulse_fire_mask =
		mask_q[`FMSC_MASK_B_HI:`FMSC_MASK_B_LO]; // [R6]
	assign o_slot_b_float_pulse_width =
		width_q[`FMSC_WIDTH_HI:`FMSC_WIDTH_LO]; // [R8]
	assign o_slot_b_float_pulse_offset =
		width_q[`FMSC_OFFSET_HI:`FMSC_OFFSET_LO];

	// Slot A fields
	assign o_slot_a_float_enable =
		ctrl_a_w[`FMSC_EN_HI:`FMSC_EN_LO]; // [R2]
	assign o_slot_a_float_on = on_w[SLOT_A]; // [R2]
	assign o_slot_a_float_precondition_time =
		ctrl_a_w[`FMSC_PRECON_HI:`FMSC_PRECON_LO]; // [R4]
	assign o_slot_a_pulse_fire_mask =
		mask_q[`FMSC_MASK_A_HI:`FMSC_MASK_A_LO]; // [R5] [R7]

endmodule // fmsc_float_cfg

// ==== tb/fmsc_float_cfg_assertions.sv ====
// Checker for the float-mode slot configuration bank.
// Assumes writes land at the edge that takes the strobe.
`timescale 1ns/1ps
module fmsc_chk (
	// Clock, reset and host write port
	input wire        i_mclk,
	input wire        i_rst_n,
	input wire        i_wr_en,
	input wire [7:0]  i_addr,
	input wire [15:0] i_wdata,
	// Field outputs of the bank
	input wire        o_slot_b_float_on,
	input wire        o_slot_a_float_on,
	input wire [4:0]  o_slot_b_float_precondition_time,
	input wire [4:0]  o_slot_a_float_precondition_time,
	input wire [4:0]  o_slot_b_float_pulse_width,
	input wire [3:0]  o_slot_b_pulse_fire_mask,
	input wire [3:0]  o_slot_a_pulse_fire_mask
);
	wire       wb = i_wr_en && i_addr == 8'h59;
	wire       wa = i_wr_en && i_addr == 8'h5E;
	wire       wm = i_wr_en && i_addr == 8'h5A;
	wire       ww = i_wr_en && i_addr == 8'h57;
	wire [1:0] en = i_wdata[14:13];
	wire [4:0] fv = i_wdata[12:8];
	wire [3:0] mb = i_wdata[15:12];
	wire [3:0] ma = i_wdata[11:8];
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	property p_onb;
		wb |=> o_slot_b_float_on == ($past(en) == 2'h3);
	endproperty
	property p_ona;
		wa |=> o_slot_a_float_on == ($past(en) == 2'h3);
	endproperty
	property p_pcb;
		wb |=> o_slot_b_float_precondition_time == $past(fv);
	endproperty
	property p_pca;
		wa |=> o_slot_a_float_precondition_time == $past(fv);
	endproperty
	property p_mb;
		wm |=> o_slot_b_pulse_fire_mask == $past(mb);
	endproperty
	property p_ma;
		wm |=> o_slot_a_pulse_fire_mask == $past(ma);
	endproperty
	property p_hold;
		!wm |=> $stable(o_slot_a_pulse_fire_mask);
	endproperty
	property p_wid;
		ww |=> o_slot_b_float_pulse_width == $past(fv);
	endproperty
	a_onb: assert property (p_onb) else $error("slot b on");
	a_ona: assert property (p_ona) else $error("slot a on");
	a_pcb: assert property (p_pcb) else $error("precon b");
	a_pca: assert property (p_pca) else $error("precon a");
	a_mb: assert property (p_mb) else $error("mask b");
	a_ma: assert property (p_ma) else $error("mask a");
	a_hold: assert property (p_hold) else $error("mask moved");
	a_wid: assert property (p_wid) else $error("width");
endmodule // fmsc_chk

bind fmsc_float_cfg fmsc_chk u_chk (
	.i_mclk                           (i_mclk),
	.i_rst_n                          (i_rst_n),
	.i_wr_en                          (i_wr_en),
	.i_addr                           (i_addr),
	.i_wdata                          (i_wdata),
	.o_slot_b_float_on                (o_slot_b_float_on),
	.o_slot_a_float_on                (o_slot_a_float_on),
	.o_slot_b_float_precondition_time (o_slot_b_float_precondition_time),
	.o_slot_a_float_precondition_time (o_slot_a_float_precondition_time),
	.o_slot_b_float_pulse_width       (o_slot_b_float_pulse_width),
	.o_slot_b_pulse_fire_mask         (o_slot_b_pulse_fire_mask),
	.o_slot_a_pulse_fire_mask         (o_slot_a_pulse_fire_mask)
);

// ==== tb/tb_top.sv ====
// Self-checking bench for the float-mode slot configuration bank.
// Assumes one-cycle host strobes and a 200 MHz clock.
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] %0t mismatch", $time); end end
module tb_top;
	reg         i_mclk = 0, i_rst_n = 0, i_wr_en = 0, i_rd_en = 0;
	reg  [7:0]  i_addr = 0;
	reg  [15:0] i_wdata = 0, d;
	wire [15:0] o_rdata;
	wire        o_rd_valid, bon, aon;
	wire [4:0]  bp, ap, bw;
	wire [7:0]  bo;
	wire [3:0]  bm, am;
	wire [1:0]  be, ae;
	int         bad_count = 0, n_tests = 0, i;
	fmsc_float_cfg dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wr_en(i_wr_en), .i_wdata(i_wdata), .i_rd_en(i_rd_en),
		.o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
		.o_slot_b_float_enable(be), .o_slot_b_float_on(bon),
		.o_slot_b_float_precondition_time(bp), .o_slot_b_pulse_fire_mask(bm),
		.o_slot_b_float_pulse_width(bw), .o_slot_b_float_pulse_offset(bo),
		.o_slot_a_float_enable(ae), .o_slot_a_float_on(aon),
		.o_slot_a_float_precondition_time(ap), .o_slot_a_pulse_fire_mask(am));
	always #2.5 i_mclk = ~i_mclk;
	function bit on(input [15:0] v);
		return v[14:13] == 2'h3;
	endfunction
	task wr(input [7:0] a, input [15:0] v);
		@(posedge i_mclk) #1 {i_addr, i_wdata, i_wr_en} = {a, v, 1'b1};
		@(posedge i_mclk) #1 i_wr_en = 0;
	endtask
	task rd(input [7:0] a, input [15:0] e);
		@(posedge i_mclk) #1 {i_addr, i_rd_en} = {a, 1'b1};
		@(posedge i_mclk) #1 i_rd_en = 0;
		`CK({o_rd_valid, o_rdata}, {1'b1, e})
	endtask
	task report_and_stop;
		$display("tests %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'h634d3a46));
		repeat (20) @(posedge i_mclk);
		#1 i_rst_n = 1;
		`CK({bp, ap}, 10'h108)
		`CK({bw, bo}, 13'h0320)
		rd(8'h57, 16'h0320);
		rd(8'h59, 16'h0808);
		rd(8'h5E, 16'h0808);
		rd(8'h5A, 16'h0010);
		for (i = 0; i < 4; i++) begin
			d = {1'b0, i[1:0], 13'h0808};
			wr(8'h59, d);
			`CK({be, bon}, {i[1:0], on(d)})
			wr(8'h5E, d);
			`CK({ae, aon}, {i[1:0], on(d)})
		end
		for (i = 0; i < 16; i++) begin
			d = 16'($urandom);
			// Reserved bits keep their defaults; first pass hits bit 12 and 9
			if (i == 0) d = 16'h1200;
			wr(8'h5A, {d[15:8], 8'h10});
			`CK({bm, am}, d[15:8])
			rd(8'h5A, {d[15:8], 8'h10});
			wr(8'h59, {3'h0, d[4:0], 8'h08});
			`CK(bp, d[4:0])
			wr(8'h5E, {3'h0, d[9:5], 8'h08});
			`CK(ap, d[9:5])
			wr(8'h57, {3'h0, d[4:0], d[15:8]});
			`CK({bw, bo}, {d[4:0], d[15:8]})
		end
		// Mid-run reset must bring the float flags, delays and masks back to their defaults
		wr(8'h59, 16'h6808);
		`CK(bon, 1'b1)
		@(posedge i_mclk) #1 i_rst_n = 0;
		repeat (3) @(posedge i_mclk);
		#1 i_rst_n = 1;
		`CK({bon, aon, bp, ap, bm, am}, {2'h0, 10'h108, 8'h00})
		rd(8'h5A, 16'h0010);
		report_and_stop;
	end
endmodule // tb_top
